// ---- pkg/exc_cfg.svh ----
/*
 * Register indices, field positions, reset values and widths of the
 * exception flag, mask and binding block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef EXC_CFG_SVH
`define EXC_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PEND_MID     10'h011
`define IDX_PEND_HIGH    10'h012
`define IDX_A_LOW        10'h014
`define IDX_A_MID        10'h015
`define IDX_A_HIGH       10'h016
`define IDX_B_LOW        10'h018
`define IDX_B_MID        10'h019
`define IDX_B_HIGH       10'h01A
`define IDX_BIND_X_OP    10'h01C
`define IDX_BIND_X_CTL   10'h01D

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define EXC_COUNT        24
`define PEND_LO_BIT      8
`define PEND_UNUSED_BIT  23
`define OP_WIDTH         4
`define EVSEL_WIDTH      5
`define BIND_ON_BIT      7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PEND         16'h0000
`define RST_MASK         24'h000000
`define RST_OP           4'h0
`define RST_ON           1'b0
`define RST_EVSEL        5'h12

`endif

// ---- pkg/exc_pkg.sv ----
/*
 * Types shared by the exception block and its surroundings.
 * Assumes exc_cfg.svh is on the include path.
 */
`default_nettype none

`include "exc_cfg.svh"

package exc_pkg;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef logic [`EXC_COUNT-1:0] exc_vec_t;

    typedef struct packed {
        logic a;
        logic a_n;
        logic b;
        logic b_n;
    } chan_ind_s;

    typedef struct packed {
        logic                  fire;
        logic [`OP_WIDTH-1:0]  op;
    } bind_cmd_s;

    typedef struct packed {
        logic [11:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

endpackage

`default_nettype wire

// ---- rtl/exception_flag_mask_bind.sv ----
/*
 * Exception pending flags, channel A and B selection masks and the
 * channel X instruction binding, reached by software over APB.
 * Assumes exception events arrive as one-cycle pulses on pclk and that
 * pin source selection and the instruction executor sit outside.
 */
`default_nettype none

`include "exc_cfg.svh"

module exception_flag_mask_bind (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire exc_pkg::apb_req_s apb_req,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire exc_pkg::exc_vec_t exc_event,
    output exc_pkg::chan_ind_s     chan_ind,
    output exc_pkg::bind_cmd_s     bind_cmd
);
    import exc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [`EXC_COUNT-1:`PEND_LO_BIT] pend_r;
    exc_vec_t                         mask_a_r;
    exc_vec_t                         mask_b_r;
    logic [`OP_WIDTH-1:0]             bind_x_op_r;
    logic                             bind_x_on_r;
    logic [`EVSEL_WIDTH-1:0]          bind_x_event_r;
    logic [31:0]                      prdata_r;
    logic [31:0]                      prdata_nxt;
    logic                             pready_r;
    logic                             pslverr_r;
    logic                             hit_nxt;
    chan_ind_s                        chan_ind_r;
    chan_ind_s                        chan_ind_nxt;
    bind_cmd_s                        bind_cmd_r;

    logic [9:0]  idx;
    logic [7:0]  wbyte;
    logic        setup;
    logic        wr_go;
    logic        bind_hit;

    assign idx   = apb_req.paddr[11:2];
    assign wbyte = apb_req.pwdata[7:0];
    assign setup = psel && !penable;
    // A write lands only at the edge where the access phase sees pready
    assign wr_go = psel && penable && pready_r && apb_req.pwrite;

    // ------------------------------------------------------------
    // Read mux and decode
    // ------------------------------------------------------------
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        hit_nxt    = 1'b1;
        unique case (idx)
            `IDX_PEND_MID: begin
                prdata_nxt[7:0] = pend_r[15:8];
            end
            `IDX_PEND_HIGH: begin
                prdata_nxt[7:0] = pend_r[23:16];
            end
            `IDX_A_LOW: begin
                prdata_nxt[7:0] = mask_a_r[7:0];
            end
            `IDX_A_MID: begin
                prdata_nxt[7:0] = mask_a_r[15:8];
            end
            `IDX_A_HIGH: begin
                prdata_nxt[7:0] = mask_a_r[23:16];
            end
            `IDX_B_LOW: begin
                prdata_nxt[7:0] = mask_b_r[7:0];
            end
            `IDX_B_MID: begin
                prdata_nxt[7:0] = mask_b_r[15:8];
            end
            `IDX_B_HIGH: begin
                prdata_nxt[7:0] = mask_b_r[23:16];
            end
            `IDX_BIND_X_OP: begin
                prdata_nxt[`OP_WIDTH-1:0] = bind_x_op_r;
            end
            `IDX_BIND_X_CTL: begin
                prdata_nxt[`BIND_ON_BIT] = bind_x_on_r;
                prdata_nxt[`EVSEL_WIDTH-1:0] = bind_x_event_r;
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    // Answer fixed at one wait-free access cycle; read data is caught
    // in the setup cycle, so an event in that very cycle shows next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (ce) begin
            if (setup) begin
                pready_r  <= 1'b1;
                pslverr_r <= !hit_nxt;
                prdata_r  <= apb_req.pwrite ? 32'h0000_0000 : prdata_nxt;
            end else begin
                pready_r  <= 1'b0;
                pslverr_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    // Event set is ORed after the clear so a same-cycle event survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= `RST_PEND;
        end else if (ce) begin
            logic [`EXC_COUNT-1:`PEND_LO_BIT] keep;
            keep = '1;
            if (wr_go && idx == `IDX_PEND_MID) begin
                keep[15:8] = wbyte;
            end
            if (wr_go && idx == `IDX_PEND_HIGH) begin
                keep[23:16] = wbyte;
            end
            pend_r <= (pend_r & keep)
                    | exc_event[`EXC_COUNT-1:`PEND_LO_BIT];
            pend_r[`PEND_UNUSED_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Channel masks
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_a_r <= `RST_MASK;
        end else if (ce && wr_go) begin
            if (idx == `IDX_A_LOW) begin
                mask_a_r[7:0] <= wbyte;
            end
            if (idx == `IDX_A_MID) begin
                mask_a_r[15:8] <= wbyte;
            end
            if (idx == `IDX_A_HIGH) begin
                mask_a_r[23:16] <= wbyte;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_b_r <= `RST_MASK;
        end else if (ce && wr_go) begin
            if (idx == `IDX_B_LOW) begin
                mask_b_r[7:0] <= wbyte;
            end
            if (idx == `IDX_B_MID) begin
                mask_b_r[15:8] <= wbyte;
            end
            if (idx == `IDX_B_HIGH) begin
                mask_b_r[23:16] <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel X binding registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bind_x_op_r    <= `RST_OP;
            bind_x_on_r    <= `RST_ON;
            bind_x_event_r <= `RST_EVSEL;
        end else if (ce && wr_go) begin
            if (idx == `IDX_BIND_X_OP) begin
                bind_x_op_r <= wbyte[`OP_WIDTH-1:0];
            end
            if (idx == `IDX_BIND_X_CTL) begin
                bind_x_on_r    <= wbyte[`BIND_ON_BIT];
                bind_x_event_r <= wbyte[`EVSEL_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Channel indications
    // ------------------------------------------------------------
    // Raw events, not pending flags, drive the pins: clearing a flag
    // never disturbs an indication already in flight
    always_comb begin
        chan_ind_nxt.a   = |(exc_event & mask_a_r);
        chan_ind_nxt.a_n = |(exc_event & ~mask_a_r);
        chan_ind_nxt.b   = |(exc_event & mask_b_r);
        chan_ind_nxt.b_n = |(exc_event & ~mask_b_r);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_ind_r <= '0;
        end else if (ce) begin
            chan_ind_r <= chan_ind_nxt;
        end
    end

    // ------------------------------------------------------------
    // Instruction trigger
    // ------------------------------------------------------------
    // Event numbers beyond the last exception never fire
    assign bind_hit = bind_x_on_r
                   && (bind_x_event_r < 5'h18)
                   && exc_event[bind_x_event_r];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bind_cmd_r <= '0;
        end else if (ce) begin
            bind_cmd_r.fire <= bind_hit;
            bind_cmd_r.op   <= bind_x_op_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign chan_ind = chan_ind_r;
    assign bind_cmd = bind_cmd_r;

endmodule

`default_nettype wire

// ---- tb/exc_asserts.sv ----
/* Port checker for the exception flag, mask and binding block.
   Assumes it is bound into exception_flag_mask_bind on pclk. */
`default_nettype none
module exc_asserts (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               ce,
    input wire logic               psel,
    input wire logic               penable,
    input wire exc_pkg::apb_req_s  apb_req,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire exc_pkg::exc_vec_t  exc_event,
    input wire exc_pkg::chan_ind_s chan_ind,
    input wire exc_pkg::bind_cmd_s bind_cmd
);
    import exc_pkg::*;
    // ----------------------------------------
    // Sequences and checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable && ce;
    endsequence
    // Read data is decoded at the setup edge, so the address is taken there
    sequence read_s(logic [11:0] a);
        setup_s ##0 (!apb_req.pwrite && apb_req.paddr == a);
    endsequence
    ack_next_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ack_once_a: assert property (!psel || penable || !ce |=> !pready)
        else $error("ready without setup");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    flag_top_a: assert property (read_s(12'h048) |=> !prdata[7])
        else $error("unused flag reads one");
    op_top_a: assert property (read_s(12'h070) |=> prdata[7:4] == 4'h0)
        else $error("op upper nibble set");
    quiet_ind_a: assert property (ce && exc_event == '0 |=> chan_ind == '0)
        else $error("indication without event");
    any_ind_a: assert property (ce && exc_event != '0 |=>
        (chan_ind.a || chan_ind.a_n) && (chan_ind.b || chan_ind.b_n))
        else $error("event lost on both forms");
    fire_cause_a: assert property (bind_cmd.fire |-> $past(exc_event) != '0)
        else $error("fire without event");
endmodule
bind exception_flag_mask_bind exc_asserts i_exc_asserts (.pclk, .presetn,
    .ce, .psel, .penable, .apb_req, .prdata, .pready, .pslverr, .exc_event,
    .chan_ind, .bind_cmd);
`default_nettype wire

// ---- tb/host_pin_model.sv ----
/* Host side pin reader: counts clocks with channel A indication high.
   Assumes chan_ind comes from the exception block on pclk. */
`default_nettype none
module host_pin_model (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire exc_pkg::chan_ind_s chan_ind,
    output logic [15:0]             hits
);
    import exc_pkg::*;
    // Level is polled once a clock, as a host reading the pin would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hits <= 16'h0000;
        else if (chan_ind.a)
            hits <= hits + 16'h0001;
    end
endmodule
`default_nettype wire

// ---- tb/exception_flag_mask_bind_tb.sv ----
/* Self-checking bench: registers over APB, flags, indications, binding.
   Assumes design, package, checker and host pin model compiled first. */
`default_nettype none
module exception_flag_mask_bind_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import exc_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pready, pslverr, err;
    apb_req_s    req = '0;
    exc_vec_t    ev_in = '0, ev, p1, p2;
    logic [31:0] prdata, rd;
    chan_ind_s   chan_ind, ei;
    bind_cmd_s   bind_cmd;
    logic [15:0] hits, c0, ea;
    logic [23:0] ma, mb;
    logic [7:0]  w;
    logic [11:0] map [9] = '{12'h044, 12'h048, 12'h050, 12'h054, 12'h058,
                             12'h060, 12'h064, 12'h068, 12'h070};
    int          err_total = 0, n_checks = 0, cyc = 0;

    always #50 pclk = ~pclk;

    exception_flag_mask_bind i_exception_flag_mask_bind (.pclk, .presetn,
        .ce, .psel, .penable, .apb_req(req), .prdata, .pready, .pslverr,
        .exc_event(ev_in), .chan_ind, .bind_cmd);
    host_pin_model i_host_pin_model (.pclk, .presetn, .chan_ind, .hits);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Under two hundred cycles expected; far above that means a hang
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask

    // Idle edge first, so a release never meets the next setup
    task automatic apb(logic [11:0] a, logic wr, logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        req <= {a, wr, 24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic chan_ind_s exp_ind(exc_vec_t e);
        return {|(e & ma), |(e & ~ma), |(e & mb), |(e & ~mb)};
    endfunction

    initial begin
        void'($urandom(95124));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (map[i]) begin
            apb(map[i], 1'b0, 8'h00);
            chk("reset", 32'h0, rd);
        end
        apb(12'h04C, 1'b0, 8'h00);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(12'h074, 1'b0, 8'h00);
        chk("bind ctl reset", 32'h12, rd);
        $display("test reset done");
        ma = $urandom;
        mb = $urandom;
        for (int i = 0; i < 3; i++) begin
            apb(12'h050 + 12'(4 * i), 1'b1, ma[8 * i +: 8]);
            apb(12'h060 + 12'(4 * i), 1'b1, mb[8 * i +: 8]);
        end
        for (int i = 0; i < 3; i++) begin
            apb(12'h050 + 12'(4 * i), 1'b0, 8'h00);
            chk("mask a", {24'h0, ma[8 * i +: 8]}, rd);
            apb(12'h060 + 12'(4 * i), 1'b0, 8'h00);
            chk("mask b", {24'h0, mb[8 * i +: 8]}, rd);
        end
        w = $urandom;
        apb(12'h070, 1'b1, w);
        apb(12'h070, 1'b0, 8'h00);
        chk("op", {28'h0, w[3:0]}, rd);
        $display("test registers done");
        p1 = '0;
        p2 = '0;
        ea = 16'h0000;
        @(negedge pclk);
        c0 = hits;
        repeat (60) begin
            @(posedge pclk);
            ei = exp_ind(p2);
            chk("ind", 32'(ei), 32'(chan_ind));
            ea += 16'(ei.a);
            ev = $urandom;
            if (ev[3])
                ev = ev & 24'h000F00;
            ev_in <= ev;
            p2 = p1;
            p1 = ev;
        end
        @(negedge pclk);
        chk("host hits", 32'(ea), 32'(hits - c0));
        @(posedge pclk) ev_in <= '0;
        $display("test indication done");
        apb(12'h044, 1'b1, 8'h00);
        apb(12'h048, 1'b1, 8'h00);
        ev = $urandom | 24'h800100;
        @(posedge pclk) ev_in <= ev;
        @(posedge pclk) ev_in <= '0;
        apb(12'h044, 1'b0, 8'h00);
        chk("flags mid", 32'(ev[15:8]), rd);
        apb(12'h048, 1'b0, 8'h00);
        chk("flags high", {25'h0, ev[22:16]}, rd);
        w = $urandom;
        apb(12'h044, 1'b1, w);
        apb(12'h044, 1'b0, 8'h00);
        chk("flags clear", 32'(ev[15:8] & w), rd);
        $display("test flags done");
        apb(12'h070, 1'b1, 8'h05);
        apb(12'h074, 1'b1, 8'h8C);
        @(posedge pclk) ev_in <= 24'h001000;
        @(posedge pclk) ev_in <= 24'h002000;
        @(negedge pclk);
        chk("fire", 32'h15, 32'(bind_cmd));
        @(posedge pclk) ev_in <= '0;
        @(negedge pclk);
        chk("no fire", 32'h0, {31'h0, bind_cmd.fire});
        // Select past the last exception must never fire
        apb(12'h074, 1'b1, 8'h98);
        @(posedge pclk) ev_in <= 24'hFFFFFF;
        @(posedge pclk) ev_in <= '0;
        @(negedge pclk);
        chk("no fire high sel", 32'h0, {31'h0, bind_cmd.fire});
        apb(12'h074, 1'b0, 8'h00);
        chk("bind ctl", 32'h98, rd);
        $display("test binding done");
        end_of_test();
    end
endmodule
`default_nettype wire
